/* common/ics_pkg.sv */
package ics_pkg;

  // ---------------------------------------------------------------
  // register indices (byte address = 4 * index)
  // ---------------------------------------------------------------
  localparam logic [5:0] IDX_RESULT0 = 6'h00;
  localparam logic [5:0] IDX_RESULT1 = 6'h02;
  localparam logic [5:0] IDX_RESULT2 = 6'h04;
  localparam logic [5:0] IDX_RESULT3 = 6'h06;
  localparam logic [5:0] IDX_CONFIG = 6'h1a;
  localparam logic [5:0] IDX_SCAN = 6'h1b;

  // ---------------------------------------------------------------
  // field positions and reset values
  // ---------------------------------------------------------------
  localparam int SEL_LSB = 14;
  localparam int SLEEP_BIT = 13;
  localparam int SEQ_EN_BIT = 15;
  localparam int SCAN_LSB = 13;
  localparam logic [15:0] CONFIG_RST = 16'h0000;
  localparam logic [15:0] SCAN_RST = 16'h0000;
  localparam logic [11:0] RESULT_RST = 12'h000;

  // ---------------------------------------------------------------
  // result codes and bus answers
  // ---------------------------------------------------------------
  localparam logic [11:0] UNDER_CODE = 12'h000;
  localparam logic [11:0] OVER_CODE = 12'hfff;
  localparam int RAW_W = 16;
  localparam int CODE_W = 12;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  localparam logic [1:0] SCAN_01 = 2'h0;
  localparam logic [1:0] SCAN_012 = 2'h1;

  typedef enum logic [1:0] {
    S_IDLE = 2'h0,
    S_SWITCH = 2'h1,
    S_START = 2'h3,
    S_WAIT = 2'h2
  } seq_state_e;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  // the two-channel variant has no channels 2 and 3: the upper select bit is dropped
  function automatic logic [1:0] clamp_sel(input logic [1:0] sel, input logic four_ch);
    clamp_sel = four_ch ? sel : {1'b0, sel[0]};
  endfunction

  function automatic logic [1:0] last_channel(input logic [1:0] scan, input logic four_ch);
    logic [1:0] last;
    last = 2'h3;
    if (scan == SCAN_01) begin
      last = 2'h1;
    end else if (scan == SCAN_012) begin
      last = 2'h2;
    end
    last_channel = four_ch ? last : 2'h1;
  endfunction

  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [15:0] wd,
                                          input logic [1:0] strb);
    merge16 = {strb[1] ? wd[15:8] : old[15:8], strb[0] ? wd[7:0] : old[7:0]};
  endfunction

endpackage

/* dv/inductive_channel_sequencer_bench.sv */
`timescale 1ns/1ps
module inductive_channel_sequencer_bench;
  // ----------------------------------------
  // signals and design
  // ----------------------------------------
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, conv_start;
  logic [1:0] s_axi_bresp, s_axi_rresp, conv_channel;
  logic conv_done = 1'b0, conv_under = 1'b0, conv_over = 1'b0;
  logic [15:0] conv_value = 16'h0000;
  logic [3:0] chan_active, sensor_pin_a_gnd, sensor_pin_b_gnd;
  int n_mismatch = 0;
  int checked = 0;
  logic [1:0] exp_b[$];
  logic [33:0] exp_r[$];
  logic [1:0] exp_ch[$];
  logic [11:0] model[4] = '{default: ics_pkg::RESULT_RST};
  logic [15:0] seed = 16'h000b;
  logic core_on = 1'b0;
  logic [2:0] wait_n = 3'h0;
  logic [1:0] cur_ch = 2'h0;
  logic [1:0] c;
  logic [11:0] code;
  logic [33:0] rexp;

  always #5 aclk = ~aclk;

  inductive_channel_sequencer #(.NUM_CH(4), .ADDR_W(8)) DUT (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .conv_start(conv_start),
    .conv_channel(conv_channel), .conv_done(conv_done), .conv_value(conv_value),
    .conv_under(conv_under), .conv_over(conv_over), .chan_active(chan_active),
    .sensor_pin_a_gnd(sensor_pin_a_gnd), .sensor_pin_b_gnd(sensor_pin_b_gnd));

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    lfsr = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  function automatic logic [7:0] ba(input logic [5:0] idx);
    ba = {idx, 2'b00};
  endfunction

  task automatic fail_note(input string what);
    n_mismatch++;
    $display("ERROR at %0t: %s", $time, what);
  endtask

  task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) fail_note($sformatf("read data %h, expected %h", got, exp));
  endtask

  task automatic cmp_resp(input logic [1:0] got, input logic [1:0] exp);
    checked++;
    if (got !== exp) fail_note($sformatf("response %h, expected %h", got, exp));
  endtask

  task automatic cmp_pins(input logic [3:0] got, input logic [3:0] exp);
    checked++;
    if (got !== exp) fail_note($sformatf("channel vector %h, expected %h", got, exp));
  endtask

  // ----------------------------------------
  // bus master
  // ----------------------------------------
  task automatic axi_write(input logic [7:0] a, input logic [15:0] d, input logic [3:0] st,
                           input logic [1:0] resp);
    logic aw_ok;
    logic w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    @(posedge aclk);
    exp_b.push_back(resp);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= {16'h0000, d};
    s_axi_wstrb <= st;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge aclk);
      if (!aw_ok && s_axi_awready) begin
        aw_ok = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w_ok && s_axi_wready) begin
        w_ok = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
  endtask

  task automatic axi_read(input logic [7:0] a, input logic [31:0] d, input logic [1:0] resp);
    @(posedge aclk);
    exp_r.push_back({d, resp});
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
  endtask

  // sleep stops after the conversion in flight, so wait for the idle vector
  task automatic halt(input logic [1:0] sel);
    axi_write(ba(ics_pkg::IDX_CONFIG), {sel, 1'b1, 13'h0000}, 4'h3, ics_pkg::RESP_OKAY);
    do @(posedge aclk); while (chan_active !== 4'h0);
    cmp_pins(sensor_pin_a_gnd, 4'hf);
    cmp_pins(sensor_pin_b_gnd, 4'hf);
  endtask

  task automatic drain;
    while (exp_ch.size() != 0) @(posedge aclk);
  endtask

  task automatic read_results;
    for (int i = 0; i < 4; i++) begin
      axi_read(8'(i * 8), {20'h00000, model[i]}, ics_pkg::RESP_OKAY);
    end
  endtask

  task automatic end_of_test;
    $display("mismatches %0d, comparisons %0d", n_mismatch, checked);
    if (n_mismatch == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // ----------------------------------------
  // converter core stand-in, random latency
  // ----------------------------------------
  always @(posedge aclk) begin
    conv_done <= 1'b0;
    if (conv_start) begin
      cur_ch <= conv_channel;
      wait_n <= {1'b0, seed[1:0]} + 3'h1;
    end else if (core_on && wait_n != 3'h0) begin
      wait_n <= wait_n - 3'h1;
      if (wait_n == 3'h1) begin
        seed = lfsr(seed);
        code = (seed[2:0] == 3'h0 || seed[2:0] == 3'h2) ? ics_pkg::UNDER_CODE :
               (seed[2:0] == 3'h1) ? ics_pkg::OVER_CODE : seed[15:4];
        model[cur_ch] <= code;
        conv_done <= 1'b1;
        conv_value <= seed;
        conv_under <= (seed[2:0] == 3'h0 || seed[2:0] == 3'h2);
        conv_over <= (seed[2:0] == 3'h1 || seed[2:0] == 3'h2);
      end
    end
  end

  // ----------------------------------------
  // output watcher
  // ----------------------------------------
  always @(posedge aclk) begin
    if (aresetn && s_axi_bvalid && s_axi_bready) begin
      cmp_resp(s_axi_bresp, exp_b.pop_front());
    end
    if (aresetn && s_axi_rvalid && s_axi_rready) begin
      rexp = exp_r.pop_front();
      cmp_word(s_axi_rdata, rexp[33:2]);
      cmp_resp(s_axi_rresp, rexp[1:0]);
    end
    if (aresetn && conv_start) begin
      cmp_pins(sensor_pin_a_gnd, ~chan_active);
      cmp_pins(sensor_pin_b_gnd, ~chan_active);
      if (exp_ch.size() != 0) begin
        c = exp_ch.pop_front();
        cmp_pins({2'b00, conv_channel}, {2'b00, c});
        cmp_pins(chan_active, 4'h1 << c);
      end
    end
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    exp_ch.push_back(2'h0);
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    axi_read(ba(ics_pkg::IDX_CONFIG), 32'h0, ics_pkg::RESP_OKAY);
    axi_read(ba(ics_pkg::IDX_SCAN), 32'h0, ics_pkg::RESP_OKAY);
    read_results();
    core_on <= 1'b1;
    drain();
    for (int s = 0; s < 4; s++) begin
      halt(2'(s));
      axi_read(ba(ics_pkg::IDX_CONFIG), {16'h0, 2'(s), 14'h2000}, ics_pkg::RESP_OKAY);
      repeat (3) exp_ch.push_back(2'(s));
      axi_write(ba(ics_pkg::IDX_RESULT0), 16'hffff, 4'h3, ics_pkg::RESP_OKAY);
      axi_write(ba(ics_pkg::IDX_CONFIG), {2'(s), 14'h0000}, 4'h3, ics_pkg::RESP_OKAY);
      drain();
    end
    halt(2'h0);
    read_results();
    // scan code 11 runs the full set, as does 10
    for (int s = 0; s < 4; s++) begin
      for (int r = 0; r < 2; r++) begin
        for (int ch = 0; ch <= ((s == 0) ? 1 : (s == 1) ? 2 : 3); ch++) begin
          exp_ch.push_back(2'(ch));
        end
      end
      axi_write(ba(ics_pkg::IDX_SCAN), {1'b1, 2'(s), 13'h0000}, 4'h3, ics_pkg::RESP_OKAY);
      axi_write(ba(ics_pkg::IDX_CONFIG), 16'h0000, 4'h3, ics_pkg::RESP_OKAY);
      drain();
      halt(2'h0);
    end
    read_results();
    axi_write(ba(ics_pkg::IDX_SCAN), 16'h0000, 4'h1, ics_pkg::RESP_OKAY);
    axi_read(ba(ics_pkg::IDX_SCAN), 32'h0000e000, ics_pkg::RESP_OKAY);
    axi_write(8'h70, 16'h1234, 4'h3, ics_pkg::RESP_SLVERR);
    axi_read(8'h70, 32'h0, ics_pkg::RESP_SLVERR);
    end_of_test();
  end

  // a few dozen conversions and bus cycles fit well inside this span
  initial begin
    repeat (20000) @(posedge aclk);
    fail_note("watchdog expired");
    end_of_test();
  end
endmodule

/* src/channel_pins.sv */
`timescale 1ns/1ps
module channel_pins #(
  parameter int NUM_CH = 4
) (
  input wire logic [1:0] chan,
  input wire logic run,
  output logic [NUM_CH-1:0] active,
  output logic [NUM_CH-1:0] gnd
);

  always_comb begin
    for (int i = 0; i < NUM_CH; i++) begin
      active[i] = run && (chan == i[1:0]);
      gnd[i] = !active[i];
    end
  end

endmodule

/* src/inductive_channel_sequencer.sv */
`timescale 1ns/1ps
// How it works
// - in multi-channel mode one channel at a time is active and every other one is inactive.
// - in multi-channel mode the selected channels are converted one after another in order.
// - in single-channel mode only the software-chosen channel is converted, over and over.
// - both sensor pins of each inactive channel are held at ground.
// - selected_channel, config bits 15:14, picks channel 0 to 3 for single-channel mode.
// - scan_control bit 15, sequence_enable, picks single (0, default) or multi-channel (1).
// - scan_set, scan_control bits 14:13, scans channels 0-1, 0-2 or 0-3 for codes 00, 01, 10.
// - channels 2 and 3 and the codes that use them exist only in the four-channel variant.
// - each result is the ratio of sensor to reference frequency, scaled by 4096.
// - each result field holds the upper 12 bits of the 16-bit conversion value.
// - an under-range sensor reports the all-zero code.
// - an over-range sensor reports the all-ones code.
module inductive_channel_sequencer #(
  parameter int NUM_CH = 4,
  parameter int ADDR_W = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic conv_start,
  output logic [1:0] conv_channel,
  input wire logic conv_done,
  input wire logic [15:0] conv_value,
  input wire logic conv_under,
  input wire logic conv_over,
  output logic [NUM_CH-1:0] chan_active,
  output logic [NUM_CH-1:0] sensor_pin_a_gnd,
  output logic [NUM_CH-1:0] sensor_pin_b_gnd
);

  // ---------------------------------------------------------------
  // elaboration checks
  // ---------------------------------------------------------------
  if (NUM_CH != 2 && NUM_CH != 4) begin : g_bad_ch
    $error("NUM_CH must be 2 or 4");
  end
  if (ADDR_W < 8 || ADDR_W > 32) begin : g_bad_addr
    $error("ADDR_W must be 8 to 32");
  end

  localparam logic FOUR_CH = (NUM_CH == 4);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    ics_pkg::seq_state_e st;
    logic [1:0] chan;
    logic restart;
    logic conv_start;
    logic [NUM_CH-1:0] active;
    logic [NUM_CH-1:0] gnd;
    logic [NUM_CH-1:0][11:0] result;
    logic [15:0] config_reg;
    logic [15:0] scan_reg;
    logic aw_held;
    logic w_held;
    logic [ADDR_W-1:0] awaddr;
    logic [15:0] wdata;
    logic [1:0] wstrb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [15:0] rdata;
  } state_s;

  state_s state_r;
  state_s state_nxt;
  logic [11:0] code;
  logic [NUM_CH-1:0] pins_active;
  logic [NUM_CH-1:0] pins_gnd;

  result_code u_code (
    .raw(conv_value),
    .under(conv_under),
    .over(conv_over),
    .code(code)
  );

  channel_pins #(.NUM_CH(NUM_CH)) u_pins (
    .chan(state_r.chan),
    .run(state_r.st != ics_pkg::S_IDLE),
    .active(pins_active),
    .gnd(pins_gnd)
  );

  // register index of an AXI byte address; upper address bits must be zero
  function automatic logic [5:0] reg_index(input logic [ADDR_W-1:0] addr, output logic in_map);
    in_map = (addr >> 8) == '0;
    reg_index = addr[7:2];
  endfunction

  // a result register exists only for a channel the variant has
  function automatic logic result_slot(input logic [5:0] idx, output logic [1:0] ch);
    ch = idx[2:1];
    result_slot = (idx[5:3] == 3'h0) && !idx[0] && (int'(idx[2:1]) < NUM_CH);
  endfunction

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    logic [5:0] idx;
    logic in_map;
    logic [1:0] ch;
    logic is_res;
    logic [1:0] last;
    logic seq_en;
    idx = '0;
    in_map = 1'b0;
    ch = '0;
    is_res = 1'b0;
    state_nxt = state_r;
    state_nxt.conv_start = 1'b0;
    seq_en = state_r.scan_reg[ics_pkg::SEQ_EN_BIT];
    last = ics_pkg::last_channel(state_r.scan_reg[ics_pkg::SCAN_LSB +: 2], FOUR_CH);

    // write channel: address and data are taken independently, in either order
    if (state_r.awready && s_axi_awvalid) begin
      state_nxt.aw_held = 1'b1;
      state_nxt.awaddr = s_axi_awaddr;
    end
    if (state_r.wready && s_axi_wvalid) begin
      state_nxt.w_held = 1'b1;
      state_nxt.wdata = s_axi_wdata[15:0];
      state_nxt.wstrb = s_axi_wstrb[1:0];
    end
    if (state_r.bvalid && s_axi_bready) begin
      state_nxt.bvalid = 1'b0;
    end
    if (state_r.aw_held && state_r.w_held && !state_r.bvalid) begin
      idx = reg_index(state_r.awaddr, in_map);
      is_res = result_slot(idx, ch);
      state_nxt.aw_held = 1'b0;
      state_nxt.w_held = 1'b0;
      state_nxt.bvalid = 1'b1;
      state_nxt.bresp = ics_pkg::RESP_OKAY;
      if (in_map && idx == ics_pkg::IDX_CONFIG) begin
        state_nxt.config_reg = ics_pkg::merge16(state_r.config_reg, state_r.wdata,
                                                state_r.wstrb);
      end else if (in_map && idx == ics_pkg::IDX_SCAN) begin
        state_nxt.scan_reg = ics_pkg::merge16(state_r.scan_reg, state_r.wdata, state_r.wstrb);
      end else if (!(in_map && is_res)) begin
        // result registers silently ignore writes; anything else is an error
        state_nxt.bresp = ics_pkg::RESP_SLVERR;
      end
    end
    state_nxt.awready = !state_nxt.aw_held && !state_nxt.bvalid;
    state_nxt.wready = !state_nxt.w_held && !state_nxt.bvalid;

    // read channel: one read in flight, data one cycle after the address is taken
    if (state_r.rvalid && s_axi_rready) begin
      state_nxt.rvalid = 1'b0;
    end
    if (state_r.arready && s_axi_arvalid) begin
      idx = reg_index(s_axi_araddr, in_map);
      is_res = result_slot(idx, ch);
      state_nxt.rvalid = 1'b1;
      state_nxt.rresp = ics_pkg::RESP_OKAY;
      state_nxt.rdata = '0;
      if (in_map && is_res) begin
        state_nxt.rdata = {4'h0, state_r.result[ch]};
      end else if (in_map && idx == ics_pkg::IDX_CONFIG) begin
        state_nxt.rdata = state_r.config_reg;
      end else if (in_map && idx == ics_pkg::IDX_SCAN) begin
        state_nxt.rdata = state_r.scan_reg;
      end else begin
        state_nxt.rresp = ics_pkg::RESP_SLVERR;
      end
    end
    state_nxt.arready = !state_nxt.rvalid;

    // sequencer: new settings take effect at the next channel switch
    case (state_r.st)
      ics_pkg::S_IDLE: begin
        if (!state_r.config_reg[ics_pkg::SLEEP_BIT]) begin
          state_nxt.st = ics_pkg::S_SWITCH;
          state_nxt.restart = 1'b1;
        end
      end
      ics_pkg::S_SWITCH: begin
        if (!seq_en) begin
          state_nxt.chan = ics_pkg::clamp_sel(state_r.config_reg[ics_pkg::SEL_LSB +: 2],
                                              FOUR_CH);
        end else if (state_r.restart || state_r.chan >= last) begin
          state_nxt.chan = 2'h0;
        end else begin
          state_nxt.chan = state_r.chan + 2'h1;
        end
        state_nxt.restart = 1'b0;
        state_nxt.st = ics_pkg::S_START;
      end
      ics_pkg::S_START: begin
        // start is issued together with the new channel's pins going live
        state_nxt.conv_start = 1'b1;
        state_nxt.st = ics_pkg::S_WAIT;
      end
      ics_pkg::S_WAIT: begin
        if (conv_done) begin
          state_nxt.result[state_r.chan] = code;
          state_nxt.st = state_r.config_reg[ics_pkg::SLEEP_BIT] ? ics_pkg::S_IDLE
                                                                 : ics_pkg::S_SWITCH;
        end
      end
      default: begin
        state_nxt.st = ics_pkg::S_IDLE;
      end
    endcase

    state_nxt.active = pins_active;
    state_nxt.gnd = pins_gnd;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_r <= '0;
      state_r.st <= ics_pkg::S_IDLE;
      state_r.config_reg <= ics_pkg::CONFIG_RST;
      state_r.scan_reg <= ics_pkg::SCAN_RST;
      for (int i = 0; i < NUM_CH; i++) begin
        state_r.result[i] <= ics_pkg::RESULT_RST;
      end
      state_r.gnd <= '1;
    end else begin
      state_r <= state_nxt;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign s_axi_awready = state_r.awready;
  assign s_axi_wready = state_r.wready;
  assign s_axi_bvalid = state_r.bvalid;
  assign s_axi_bresp = state_r.bresp;
  assign s_axi_arready = state_r.arready;
  assign s_axi_rvalid = state_r.rvalid;
  assign s_axi_rresp = state_r.rresp;
  assign s_axi_rdata = {16'h0000, state_r.rdata};
  assign conv_start = state_r.conv_start;
  assign conv_channel = state_r.chan;
  assign chan_active = state_r.active;
  assign sensor_pin_a_gnd = state_r.gnd;
  assign sensor_pin_b_gnd = state_r.gnd;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  logic seq_en_now;
  logic [1:0] sel_now;
  logic [1:0] last_now;
  assign seq_en_now = state_r.scan_reg[ics_pkg::SEQ_EN_BIT];
  assign sel_now = ics_pkg::clamp_sel(state_r.config_reg[ics_pkg::SEL_LSB +: 2], FOUR_CH);
  assign last_now = ics_pkg::last_channel(state_r.scan_reg[ics_pkg::SCAN_LSB +: 2], FOUR_CH);

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  sequence s_switch_start;
    ##1 (state_r.st == ics_pkg::S_SWITCH) ##1 (state_r.st == ics_pkg::S_START)
      ##1 conv_start;
  endsequence

  a_one_active: assert property (conv_start |-> $onehot(chan_active)
    && chan_active[conv_channel]) else $error("not exactly the converting channel active");
  a_pins_grounded: assert property ((sensor_pin_a_gnd | chan_active) == '1
    && (sensor_pin_b_gnd | chan_active) == '1) else $error("inactive channel pin not grounded");
  a_single_target: assert property (conv_start && !$past(seq_en_now, 2)
    |-> conv_channel == $past(sel_now, 2)) else $error("single mode converted wrong channel");
  a_scan_step: assert property (conv_start && $past(seq_en_now, 2)
    && !$past(state_r.restart, 2) && $past(state_r.chan, 2) < $past(last_now, 2)
    |-> conv_channel == $past(state_r.chan, 2) + 2'h1) else $error("scan did not step");
  a_scan_wrap: assert property (conv_start && $past(seq_en_now, 2)
    && $past(state_r.chan, 2) >= $past(last_now, 2) |-> conv_channel == 2'h0)
    else $error("scan did not wrap to channel 0");
  a_scan_range: assert property (conv_start && $past(seq_en_now, 2)
    |-> conv_channel <= $past(last_now, 2)) else $error("scan left the scan set");
  a_variant_limit: assert property (int'(conv_channel) < NUM_CH)
    else $error("channel beyond variant");
  a_mode_default: assert property ($past(!aresetn) |-> !seq_en_now)
    else $error("sequence_enable not cleared by reset");
  a_result_ratio: assert property (state_r.st == ics_pkg::S_WAIT && conv_done
    && !conv_under && !conv_over |=> state_r.result[$past(conv_channel)] == $past(conv_value[15:4]))
    else $error("result not upper 12 bits");
  a_under_code: assert property (state_r.st == ics_pkg::S_WAIT && conv_done
    && conv_under |=> state_r.result[$past(conv_channel)] == 12'h000)
    else $error("under-range code wrong");
  a_over_code: assert property (state_r.st == ics_pkg::S_WAIT && conv_done
    && conv_over && !conv_under |=> state_r.result[$past(conv_channel)] == 12'hfff)
    else $error("over-range code wrong");
  a_done_restart: assert property (state_r.st == ics_pkg::S_WAIT && conv_done
    && !state_r.config_reg[ics_pkg::SLEEP_BIT] |-> s_switch_start)
    else $error("next conversion not started after done");

endmodule

/* src/result_code.sv */
`timescale 1ns/1ps
module result_code (
  input wire logic [15:0] raw,
  input wire logic under,
  input wire logic over,
  output logic [11:0] code
);

  // under-range wins when the core flags both
  always_comb begin
    if (under) begin
      code = ics_pkg::UNDER_CODE;
    end else if (over) begin
      code = ics_pkg::OVER_CODE;
    end else begin
      code = raw[ics_pkg::RAW_W-1 -: ics_pkg::CODE_W];
    end
  end

endmodule
